// ### dtc_interval.sv
// Function
// - remote one interval code is a read/write field at bits two to zero.
// - decrease interval 8 shl code monitoring cycles; increase interval twice that.
// - one monitoring cycle lasts one eighth of a second.
// - local interval code is a read/write field at bits five to three.
// - local loop waits its own coded interval, same table as remote.
// - once lock is one, register writes are ignored.
// - intervals act only when the channel's dynamic enable is one.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module dtc_interval #(
  parameter int unsigned TICK_CYCLES = int'(dtc_pkg::MON_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic remoteAdjusted,
  input wire logic localAdjusted,
  output logic [2:0] remoteOneIntervalCode,
  output logic [2:0] localIntervalCode,
  output logic remoteDecreaseAllow,
  output logic remoteIncreaseAllow,
  output logic localDecreaseAllow,
  output logic localIncreaseAllow
);

  function automatic logic [11:0] decInterval(input logic [2:0] code);
    return dtc_pkg::BASE_DEC_CYCLES << code;
  endfunction : decInterval

  function automatic logic [11:0] incInterval(input logic [2:0] code);
    return decInterval(code) << 1;
  endfunction : incInterval

  logic [5:0] intervalReg;
  logic [5:0] next_intervalReg;
  logic [1:0] enable;
  logic [1:0] next_enable;
  logic lock;
  logic next_lock;
  logic [31:0] next_prdata;
  logic [21:0] tickCnt;
  logic [21:0] next_tickCnt;
  logic tick;
  logic access;
  logic mapped;
  logic regWrite;
  logic [1:0][2:0] code;
  // unpacked so that each channel's always_ff owns its own elements
  logic [11:0] cnt [2];
  logic decAllow [2];
  logic incAllow [2];
  logic [1:0] adjusted;

  assign access = psel && penable;
  assign mapped = (paddr == dtc_pkg::ADDR_INTERVAL) ||
                  (paddr == dtc_pkg::ADDR_CONTROL) ||
                  (paddr == dtc_pkg::ADDR_STAT_REMOTE) ||
                  (paddr == dtc_pkg::ADDR_STAT_LOCAL);
  // zero wait states: read data is captured during the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign regWrite = access && pwrite && !lock;

  always_comb begin
    next_intervalReg = intervalReg;
    next_enable = enable;
    next_lock = lock;
    next_prdata = prdata;
    if (regWrite && paddr == dtc_pkg::ADDR_INTERVAL) begin
      // bits above five are outside both channels' code fields and are dropped
      next_intervalReg = pwdata[5:0];
    end
    if (regWrite && paddr == dtc_pkg::ADDR_CONTROL) begin
      next_enable[0] = pwdata[dtc_pkg::CTRL_REMOTE_EN_BIT];
      next_enable[1] = pwdata[dtc_pkg::CTRL_LOCAL_EN_BIT];
      next_lock = pwdata[dtc_pkg::CTRL_LOCK_BIT];
    end
    if (psel && !penable && !pwrite) begin
      next_prdata = 32'h00000000;
      case (paddr)
        dtc_pkg::ADDR_INTERVAL: begin
          next_prdata[5:0] = intervalReg;
        end
        dtc_pkg::ADDR_CONTROL: begin
          next_prdata[dtc_pkg::CTRL_REMOTE_EN_BIT] = enable[0];
          next_prdata[dtc_pkg::CTRL_LOCAL_EN_BIT] = enable[1];
          next_prdata[dtc_pkg::CTRL_LOCK_BIT] = lock;
        end
        dtc_pkg::ADDR_STAT_REMOTE: begin
          next_prdata[11:0] = cnt[0];
          next_prdata[dtc_pkg::STAT_DEC_BIT] = decAllow[0];
          next_prdata[dtc_pkg::STAT_INC_BIT] = incAllow[0];
        end
        dtc_pkg::ADDR_STAT_LOCAL: begin
          next_prdata[11:0] = cnt[1];
          next_prdata[dtc_pkg::STAT_DEC_BIT] = decAllow[1];
          next_prdata[dtc_pkg::STAT_INC_BIT] = incAllow[1];
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      intervalReg <= dtc_pkg::INTERVAL_RESET;
      enable <= dtc_pkg::ENABLE_RESET;
      lock <= dtc_pkg::LOCK_RESET;
      prdata <= 32'h00000000;
    end else begin
      intervalReg <= next_intervalReg;
      enable <= next_enable;
      lock <= next_lock;
      prdata <= next_prdata;
    end
  end

  // monitoring cycle timebase
  assign tick = (tickCnt == 22'(TICK_CYCLES - 1));

  always_comb begin
    next_tickCnt = tick ? dtc_pkg::TICK_RESET : tickCnt + 22'h000001;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tickCnt <= dtc_pkg::TICK_RESET;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  assign code[0] = intervalReg[dtc_pkg::REMOTE_CODE_LSB +: dtc_pkg::CODE_W];
  assign code[1] = intervalReg[dtc_pkg::LOCAL_CODE_LSB +: dtc_pkg::CODE_W];
  assign adjusted = {localAdjusted, remoteAdjusted};

  for (genvar c = 0; c < 2; c++) begin : gChan
    logic [11:0] next_cnt;
    logic next_dec;
    logic next_inc;
    logic [2:0] nextCode;

    always_comb begin
      nextCode = (c == 0) ?
        next_intervalReg[dtc_pkg::REMOTE_CODE_LSB +: dtc_pkg::CODE_W] :
        next_intervalReg[dtc_pkg::LOCAL_CODE_LSB +: dtc_pkg::CODE_W];
      next_cnt = cnt[c];
      if (!enable[c]) begin
        next_cnt = dtc_pkg::CNT_RESET;
      end else if (adjusted[c]) begin
        next_cnt = dtc_pkg::CNT_RESET;
      end else if (tick && cnt[c] < incInterval(code[c])) begin
        // saturating at the increase interval keeps the count in 12 bits
        next_cnt = cnt[c] + 12'h001;
      end
      next_dec = next_enable[c] && enable[c] &&
                 next_cnt >= decInterval(nextCode);
      next_inc = next_enable[c] && enable[c] &&
                 next_cnt >= incInterval(nextCode);
    end

    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        cnt[c] <= dtc_pkg::CNT_RESET;
        decAllow[c] <= 1'b0;
        incAllow[c] <= 1'b0;
      end else begin
        cnt[c] <= next_cnt;
        decAllow[c] <= next_dec;
        incAllow[c] <= next_inc;
      end
    end
  end

  assign remoteOneIntervalCode = code[0];
  assign localIntervalCode = code[1];
  assign remoteDecreaseAllow = decAllow[0];
  assign remoteIncreaseAllow = incAllow[0];
  assign localDecreaseAllow = decAllow[1];
  assign localIncreaseAllow = incAllow[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence sIntervalWrite;
    access && pwrite && paddr == dtc_pkg::ADDR_INTERVAL;
  endsequence

  sequence sAdjustEnabled(int ch);
    adjusted[ch] && enable[ch] && $stable(enable[ch]);
  endsequence

  AST_REMOTE_FIELD: assert property (
    sIntervalWrite ##0 !lock |=> remoteOneIntervalCode == $past(pwdata[2:0]))
    else $error("remote interval code not written");

  AST_REMOTE_TABLE: assert property (
    $rose(remoteDecreaseAllow) && $stable(code[0]) && enable[0] |->
      cnt[0] == decInterval(code[0]) && !remoteIncreaseAllow)
    else $error("remote decrease interval wrong");

  AST_TICK_PERIOD: assert property (
    tick |=> !tick && tickCnt == 22'h000000)
    else $error("monitoring cycle timebase wrong");

  AST_LOCAL_FIELD: assert property (
    sIntervalWrite ##0 !lock |=> localIntervalCode == $past(pwdata[5:3]))
    else $error("local interval code not written");

  AST_LOCAL_TABLE: assert property (
    $rose(localIncreaseAllow) && $stable(code[1]) && enable[1] |->
      cnt[1] == incInterval(code[1]) && localDecreaseAllow)
    else $error("local increase interval wrong");

  AST_LOCK_HOLD: assert property (
    lock && access && pwrite |=> $stable(intervalReg) && $stable(enable) &&
      lock)
    else $error("write accepted while locked");

  AST_DISABLED_IDLE: assert property (
    !enable[0] ##1 !enable[0] |-> cnt[0] == 12'h000 &&
      !remoteDecreaseAllow && !remoteIncreaseAllow)
    else $error("disabled remote channel adjusting");

  AST_RESTART: assert property (
    sAdjustEnabled(1) |=> cnt[1] == 12'h000 ##1
      (!localDecreaseAllow && !localIncreaseAllow) [*2])
    else $error("local counter not restarted");

  AST_COUNT_ON_TICK: assert property (
    enable[0] && $past(enable[0]) && !$past(adjusted[0]) && !$past(tick) |->
      cnt[0] == $past(cnt[0]))
    else $error("remote counter moved without a tick");

endmodule : dtc_interval

// ### dtc_pkg.sv
package dtc_pkg;
  // register map
  localparam logic [7:0] ADDR_INTERVAL = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STAT_REMOTE = 8'h08;
  localparam logic [7:0] ADDR_STAT_LOCAL = 8'h0C;
  // interval register fields
  localparam int CODE_W = 3;
  localparam int REMOTE_CODE_LSB = 0;
  localparam int LOCAL_CODE_LSB = 3;
  localparam int INTERVAL_W = 6;
  localparam logic [5:0] INTERVAL_RESET = 6'h00;
  // control register fields
  localparam int CTRL_REMOTE_EN_BIT = 0;
  localparam int CTRL_LOCAL_EN_BIT = 1;
  localparam int CTRL_LOCK_BIT = 7;
  localparam logic [1:0] ENABLE_RESET = 2'h0;
  localparam logic LOCK_RESET = 1'b0;
  // status register fields
  localparam int CNT_W = 12;
  localparam int STAT_DEC_BIT = 12;
  localparam int STAT_INC_BIT = 13;
  localparam logic [11:0] CNT_RESET = 12'h000;
  // shortest decrease interval in monitoring cycles
  localparam logic [11:0] BASE_DEC_CYCLES = 12'h008;
  // monitoring cycle timing
  localparam longint MON_PERIOD_NS = 125000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint MON_CYCLES = MON_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 22;
  localparam logic [21:0] TICK_RESET = 22'h000000;
endpackage : dtc_pkg

// ### tb.sv
`timescale 1ns/1ns
module tb;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic remoteAdjusted = 1'b0;
  logic localAdjusted = 1'b0;
  logic [2:0] remoteOneIntervalCode;
  logic [2:0] localIntervalCode;
  wire [3:0] allows;
  int n_mismatch = 0;
  int num_checks = 0;
  always #20 mclk = ~mclk;
  // short tick keeps the longest interval to a few thousand clocks
  dtc_interval #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remoteAdjusted(remoteAdjusted), .localAdjusted(localAdjusted),
    .remoteOneIntervalCode(remoteOneIntervalCode),
    .localIntervalCode(localIntervalCode),
    .remoteDecreaseAllow(allows[0]), .remoteIncreaseAllow(allows[1]),
    .localDecreaseAllow(allows[2]), .localIncreaseAllow(allows[3]));

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  task apb(input logic isWrite, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= isWrite;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
  endtask : rd_chk

  // waits for one allow flag; n counts clocks since the adjustment
  task wait_on(input int idx, input int lim, inout int n);
    while (allows[idx] !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim) begin
        n_mismatch++;
        print_verdict;
      end
    end
  endtask : wait_on

  // the other channel gets the inverted code so a swapped field shows
  task meas(input logic loc, input logic [2:0] c);
    int d;
    int n;
    d = 8 << c;
    n = 0;
    wr(dtc_pkg::ADDR_INTERVAL, loc ? {26'h0, c, ~c} : {26'h0, ~c, c});
    @(posedge mclk);
    if (loc) localAdjusted <= 1'b1;
    else remoteAdjusted <= 1'b1;
    @(posedge mclk);
    localAdjusted <= 1'b0;
    remoteAdjusted <= 1'b0;
    #1;
    check(allows[loc*2] | allows[loc*2+1], 1'b0);
    wait_on(loc * 2, 2 * d * TK + 9, n);
    check(n >= (d - 1) * TK && n <= d * TK + 2, 1'b1);
    check(allows[loc*2+1], 1'b0);
    wait_on(loc * 2 + 1, 2 * d * TK + 9, n);
    check(n >= (2*d - 1) * TK && n <= 2*d * TK + 2, 1'b1);
    // count saturates at the increase interval with both allows set
    rd_chk(loc ? dtc_pkg::ADDR_STAT_LOCAL : dtc_pkg::ADDR_STAT_REMOTE,
           32'h00003000 | 2 * d);
    $display("interval test loc %0d code %0d done", loc, c);
  endtask : meas

  task t_fields;
    logic [31:0] r;
    logic e;
    rd_chk(dtc_pkg::ADDR_INTERVAL, {26'h0, dtc_pkg::INTERVAL_RESET});
    wr(dtc_pkg::ADDR_INTERVAL, 32'h000000EA);
    rd_chk(dtc_pkg::ADDR_INTERVAL, 32'h0000002A);
    check(remoteOneIntervalCode, 3'h2);
    check(localIntervalCode, 3'h5);
    apb(1'b0, 8'h10, 32'h00000000, r, e);
    check(e, 1'b1);
    check(r, 32'h00000000);
    $display("field test done");
  endtask : t_fields

  task t_disabled;
    int i;
    wr(dtc_pkg::ADDR_CONTROL, 32'h00000000);
    @(posedge mclk);
    remoteAdjusted <= 1'b1;
    localAdjusted <= 1'b1;
    @(posedge mclk);
    remoteAdjusted <= 1'b0;
    localAdjusted <= 1'b0;
    for (i = 0; i < 120; i++) @(posedge mclk);
    #1;
    check(allows, 4'h0);
    rd_chk(dtc_pkg::ADDR_STAT_REMOTE, 32'h00000000);
    rd_chk(dtc_pkg::ADDR_STAT_LOCAL, 32'h00000000);
    $display("disable test done");
  endtask : t_disabled

  task t_lock;
    wr(dtc_pkg::ADDR_INTERVAL, 32'h00000009);
    wr(dtc_pkg::ADDR_CONTROL, 32'h00000080);
    wr(dtc_pkg::ADDR_INTERVAL, 32'h0000003F);
    rd_chk(dtc_pkg::ADDR_INTERVAL, 32'h00000009);
    check(remoteOneIntervalCode, 3'h1);
    check(localIntervalCode, 3'h1);
    wr(dtc_pkg::ADDR_CONTROL, 32'h00000003);
    rd_chk(dtc_pkg::ADDR_CONTROL, 32'h00000080);
    check(allows, 4'h0);
    $display("lock test done");
  endtask : t_lock

  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_fields;
    wr(dtc_pkg::ADDR_CONTROL, 32'h00000003);
    for (int c = 0; c < 8; c++) meas(1'b0, 3'(c));
    for (int c = 0; c < 4; c++) meas(1'b1, 3'(c));
    t_disabled;
    t_lock;
    print_verdict;
  end
endmodule : tb
